/* knock_and_stillness_detector.sv */
// How it works
// - Stillness only when all axes stay quiet
// - Stillness time 24 bits over three bytes
// - One stillness unit is 500 us
// - Nonzero time requires full quiet duration
// - Selected axis magnitude compared to knock level
// - Knock level scale is 500 mg
// - Zero knock level disables all knocks
// - Knock longer than max length is rejected
// - Gap delay before second knock window
// - Zero gap delay disables double knock
// - Second knock must fall within window
// - Stillness compares shifted magnitude to 11-bit level
// - High time byte sits below middle byte
// - Two-bit field selects X, Y or Z
// - One bit enables triple knock detection
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module knock_and_stillness_detector
    import knock_pkg::*;
#(
    parameter int TICK_CYCLES = BASE_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire sample_t sample,
    output event_t events,
    output logic [3:0] flags,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    initial begin
        if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin
            $error("knock_and_stillness_detector: TICK_CYCLES out of range");
        end
    end

    det_state_t st_ff;
    det_state_t nxt_st;
    logic tick;

    // 125 us base tick for every timer
    tick_divider #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick)
    );

    // Magnitude of a signed sample
    function automatic logic [SAMPLE_W-1:0] mag(input logic signed [SAMPLE_W-1:0] v);
        mag = v[SAMPLE_W-1] ? SAMPLE_W'(-v) : v;
    endfunction

    // Register read decode
    function automatic logic [31:0] read_reg(input det_state_t s, input logic [6:0] idx);
        read_reg = 32'h0000_0000;
        unique case (idx)
            IDX_STILL_LEVEL_HIGH: read_reg[2:0] = s.still_level[10:8];
            IDX_STILL_LEVEL_LOW: read_reg[7:0] = s.still_level[7:0];
            IDX_STILL_TIME_HIGH: read_reg[7:0] = s.still_time[23:16];
            IDX_STILL_TIME_MID: read_reg[7:0] = s.still_time[15:8];
            IDX_STILL_TIME_LOW: read_reg[7:0] = s.still_time[7:0];
            IDX_KNOCK_LEVEL: read_reg[7:0] = s.knock_level;
            IDX_KNOCK_MAX_LENGTH: read_reg[7:0] = s.knock_len;
            IDX_KNOCK_GAP_DELAY: read_reg[7:0] = s.knock_gap;
            IDX_SECOND_KNOCK_WINDOW: read_reg[7:0] = s.knock_win;
            IDX_KNOCK_SETUP: read_reg[2:0] = {s.triple_en, s.axis_sel};
            IDX_EVENT_STATUS: read_reg[3:0] = s.flags;
            default: read_reg = 32'h0000_0000;
        endcase
    endfunction

    // Mapped register test
    function automatic logic is_mapped(input logic [6:0] idx);
        is_mapped = (idx >= IDX_STILL_LEVEL_HIGH && idx <= IDX_KNOCK_SETUP) ||
            idx == IDX_EVENT_STATUS;
    endfunction

    logic [6:0] wr_idx;
    logic [6:0] rd_idx;
    logic wr_go;
    logic rd_go;
    logic [SAMPLE_W+3:0] shx;
    logic [SAMPLE_W+3:0] shy;
    logic [SAMPLE_W+3:0] shz;
    logic [SAMPLE_W-1:0] axis_mag;
    logic [7:0] knock_mag;
    logic [26:0] still_need;
    logic [11:0] len_limit;
    logic [11:0] gap_limit;
    logic [11:0] win_limit;
    logic [1:0] knock_next_num;
    event_t set_evt;
    logic [3:0] clr_bits;

    // Bus handshakes, write takes address and data together
    assign wr_idx = s_axi_awaddr[8:2];
    assign rd_idx = s_axi_araddr[8:2];
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~st_ff.bvalid & ce;
    assign rd_go = s_axi_arvalid & ~st_ff.rvalid & ce;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;

    // Shifted magnitudes for stillness
    assign shx = {mag(sample.x), 4'h0};
    assign shy = {mag(sample.y), 4'h0};
    assign shz = {mag(sample.z), 4'h0};

    // Selected knock axis magnitude
    always_comb begin
        unique case (st_ff.axis_sel)
            AXIS_Y: axis_mag = mag(sample.y);
            AXIS_Z: axis_mag = mag(sample.z);
            default: axis_mag = mag(sample.x);
        endcase
    end
    assign knock_mag = axis_mag[SAMPLE_W-1:4];

    // Limits in base ticks
    assign still_need = 27'(st_ff.still_time) * 27'(STILL_UNIT_TICKS);
    assign len_limit = 12'(st_ff.knock_len) * 12'(KNOCK_LEN_UNIT_TICKS);
    assign gap_limit = 12'(st_ff.knock_gap) * 12'(KNOCK_GAP_UNIT_TICKS);
    assign win_limit = 12'(st_ff.knock_win) * 12'(KNOCK_GAP_UNIT_TICKS);
    assign knock_next_num = st_ff.knock_num + 2'h1;

    // Detector, register file and bus slave
    always_comb begin
        nxt_st = st_ff;
        set_evt = '0;
        clr_bits = 4'h0;

        // Sample-driven levels
        if (sample.valid) begin
            nxt_st.quiet = (shx < 16'(st_ff.still_level)) && (shy < 16'(st_ff.still_level)) &&
                (shz < 16'(st_ff.still_level));
            nxt_st.above = knock_mag > st_ff.knock_level;
        end

        // Stillness timer
        if (!st_ff.quiet) begin
            nxt_st.still_cnt = 27'h0;
            nxt_st.still_done = 1'b0;
        end else begin
            if (tick && st_ff.still_cnt != 27'h7FF_FFFF) begin
                nxt_st.still_cnt = st_ff.still_cnt + 27'h1;
            end
            if (!st_ff.still_done && st_ff.still_cnt >= still_need) begin
                set_evt.still = 1'b1;
                nxt_st.still_done = 1'b1;
            end
        end

        // Knock timer
        if (tick && st_ff.knock_cnt != 12'hFFF) begin
            nxt_st.knock_cnt = st_ff.knock_cnt + 12'h1;
        end

        // Knock sequence
        unique case (st_ff.knock_st)
            KNOCK_IDLE: begin
                nxt_st.knock_num = 2'h0;
                if (st_ff.above) begin
                    nxt_st.knock_st = KNOCK_HIGH;
                    nxt_st.knock_cnt = 12'h0;
                    nxt_st.too_long = 1'b0;
                end
            end
            KNOCK_HIGH: begin
                if (st_ff.knock_cnt > len_limit) begin
                    nxt_st.too_long = 1'b1;
                end
                if (!st_ff.above) begin
                    nxt_st.knock_cnt = 12'h0;
                    if (st_ff.too_long || st_ff.knock_cnt > len_limit) begin
                        nxt_st.knock_st = KNOCK_IDLE;
                    end else begin
                        nxt_st.knock_num = knock_next_num;
                        set_evt.tap = (knock_next_num == 2'h1);
                        set_evt.double_tap = (knock_next_num == 2'h2);
                        set_evt.triple = (knock_next_num == 2'h3);
                        if (st_ff.knock_gap == 8'h00 || knock_next_num == 2'h3 ||
                            (knock_next_num == 2'h2 && !st_ff.triple_en)) begin
                            nxt_st.knock_st = KNOCK_IDLE;
                        end else begin
                            nxt_st.knock_st = KNOCK_LATENT;
                        end
                    end
                end
            end
            KNOCK_LATENT: begin
                if (st_ff.knock_cnt >= gap_limit) begin
                    nxt_st.knock_st = KNOCK_WINDOW;
                    nxt_st.knock_cnt = 12'h0;
                end
            end
            KNOCK_WINDOW: begin
                if (st_ff.above) begin
                    nxt_st.knock_st = KNOCK_HIGH;
                    nxt_st.knock_cnt = 12'h0;
                    nxt_st.too_long = 1'b0;
                end else if (st_ff.knock_cnt >= win_limit) begin
                    nxt_st.knock_st = KNOCK_IDLE;
                end
            end
        endcase

        // Zero level keeps the knock detector parked
        if (st_ff.knock_level == 8'h00) begin
            nxt_st.knock_st = KNOCK_IDLE;
            set_evt.tap = 1'b0;
            set_evt.double_tap = 1'b0;
            set_evt.triple = 1'b0;
        end

        // Register writes, lane 0 only
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_go) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
                unique case (wr_idx)
                    IDX_STILL_LEVEL_HIGH: nxt_st.still_level[10:8] = s_axi_wdata[2:0];
                    IDX_STILL_LEVEL_LOW: nxt_st.still_level[7:0] = s_axi_wdata[7:0];
                    IDX_STILL_TIME_HIGH: nxt_st.still_time[23:16] = s_axi_wdata[7:0];
                    IDX_STILL_TIME_MID: nxt_st.still_time[15:8] = s_axi_wdata[7:0];
                    IDX_STILL_TIME_LOW: nxt_st.still_time[7:0] = s_axi_wdata[7:0];
                    IDX_KNOCK_LEVEL: nxt_st.knock_level = s_axi_wdata[7:0];
                    IDX_KNOCK_MAX_LENGTH: nxt_st.knock_len = s_axi_wdata[7:0];
                    IDX_KNOCK_GAP_DELAY: nxt_st.knock_gap = s_axi_wdata[7:0];
                    IDX_SECOND_KNOCK_WINDOW: nxt_st.knock_win = s_axi_wdata[7:0];
                    IDX_KNOCK_SETUP: begin
                        nxt_st.axis_sel = s_axi_wdata[SETUP_AXIS_LSB +: 2];
                        nxt_st.triple_en = s_axi_wdata[SETUP_TRIPLE_BIT];
                    end
                    IDX_EVENT_STATUS: clr_bits = s_axi_wdata[3:0];
                    default: clr_bits = 4'h0;
                endcase
            end
        end

        // Sticky flags, set wins over clear
        nxt_st.flags = (st_ff.flags & ~clr_bits) |
            {set_evt.still, set_evt.triple, set_evt.double_tap, set_evt.tap};
        nxt_st.evt = set_evt;

        // Register reads
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (rd_go) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = read_reg(st_ff, rd_idx);
            nxt_st.rresp = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.knock_st <= KNOCK_IDLE;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign events = st_ff.evt;
    assign flags = st_ff.flags;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

endmodule // knock_and_stillness_detector

/* knock_pkg.sv */
package knock_pkg;

    // Bus and data widths
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;
    localparam int SAMPLE_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_STILL_LEVEL_HIGH = 7'h3E;
    localparam logic [6:0] IDX_STILL_LEVEL_LOW = 7'h3F;
    localparam logic [6:0] IDX_STILL_TIME_HIGH = 7'h40;
    localparam logic [6:0] IDX_STILL_TIME_MID = 7'h41;
    localparam logic [6:0] IDX_STILL_TIME_LOW = 7'h42;
    localparam logic [6:0] IDX_KNOCK_LEVEL = 7'h43;
    localparam logic [6:0] IDX_KNOCK_MAX_LENGTH = 7'h44;
    localparam logic [6:0] IDX_KNOCK_GAP_DELAY = 7'h45;
    localparam logic [6:0] IDX_SECOND_KNOCK_WINDOW = 7'h46;
    localparam logic [6:0] IDX_KNOCK_SETUP = 7'h47;
    localparam logic [6:0] IDX_EVENT_STATUS = 7'h50;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Field positions
    localparam int SETUP_AXIS_LSB = 0;
    localparam int SETUP_TRIPLE_BIT = 2;
    localparam int FLAG_TAP = 0;
    localparam int FLAG_DOUBLE = 1;
    localparam int FLAG_TRIPLE = 2;
    localparam int FLAG_STILL = 3;

    // Axis selection codes
    localparam logic [1:0] AXIS_X = 2'h0;
    localparam logic [1:0] AXIS_Y = 2'h1;
    localparam logic [1:0] AXIS_Z = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing: one base tick, all units are whole multiples of it
    localparam int CLK_PERIOD_NS = 100;
    localparam int BASE_TICK_NS = 125000;
    localparam int BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
    localparam int STILL_UNIT_US = 500;
    localparam int KNOCK_LEN_UNIT_US = 625;
    localparam int KNOCK_GAP_UNIT_US = 1250;
    localparam int BASE_TICK_US = BASE_TICK_NS / 1000;
    localparam logic [2:0] STILL_UNIT_TICKS = 3'(STILL_UNIT_US / BASE_TICK_US);
    localparam logic [2:0] KNOCK_LEN_UNIT_TICKS = 3'(KNOCK_LEN_UNIT_US / BASE_TICK_US);
    localparam logic [3:0] KNOCK_GAP_UNIT_TICKS = 4'(KNOCK_GAP_UNIT_US / BASE_TICK_US);

    // One sample of all three axes
    typedef struct packed {
        logic valid;
        logic signed [SAMPLE_W-1:0] x;
        logic signed [SAMPLE_W-1:0] y;
        logic signed [SAMPLE_W-1:0] z;
    } sample_t;

    // Detected events, one-cycle pulses
    typedef struct packed {
        logic still;
        logic triple;
        logic double_tap;
        logic tap;
    } event_t;

    typedef enum logic [1:0] {
        KNOCK_IDLE,
        KNOCK_HIGH,
        KNOCK_LATENT,
        KNOCK_WINDOW
    } knock_state_t;

    // Whole state of the detector
    typedef struct packed {
        logic [10:0] still_level;
        logic [23:0] still_time;
        logic [7:0] knock_level;
        logic [7:0] knock_len;
        logic [7:0] knock_gap;
        logic [7:0] knock_win;
        logic [1:0] axis_sel;
        logic triple_en;
        logic [3:0] flags;
        logic quiet;
        logic above;
        logic [26:0] still_cnt;
        logic still_done;
        knock_state_t knock_st;
        logic [11:0] knock_cnt;
        logic [1:0] knock_num;
        logic too_long;
        event_t evt;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } det_state_t;

endpackage

/* knock_props.sv */
`timescale 1ns/1ps
module knock_props
    import knock_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire event_t events,
    input wire logic [3:0] flags,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Bus handshake and answer timing
    a_write_taken: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid) else $error("write taken without both halves");
    a_write_answer: assert property (s_axi_awready |=> s_axi_bvalid)
        else $error("write answer late");
    a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
    a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");

    // Events and sticky flags
    a_tap_flag: assert property (events.tap |-> flags[FLAG_TAP])
        else $error("tap flag missing");
    a_double_flag: assert property (events.double_tap |-> flags[FLAG_DOUBLE])
        else $error("double flag missing");
    a_still_flag: assert property (events.still |-> flags[FLAG_STILL])
        else $error("stillness flag missing");
    a_double_pulse: assert property (events.double_tap |=> !events.double_tap)
        else $error("double pulse too long");
    a_reset_clear: assert property ($rose(aresetn) |-> flags == 4'h0 && events == 4'h0
        && !s_axi_bvalid && !s_axi_rvalid) else $error("state not cleared by reset");

    // Main scenarios
    c_read: cover property (s_axi_arready);
    c_double: cover property (events.double_tap);
    c_triple: cover property (events.triple);
    c_still: cover property (events.still);
endmodule // knock_props

bind knock_and_stillness_detector knock_props u_props (.aclk, .aresetn, .events, .flags,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bresp, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rready);

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_top
    import knock_pkg::*;
;
    logic aclk, aresetn, ce;
    sample_t sample;
    event_t events;
    logic [3:0] flags, s_axi_wstrb;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] rd_d;
    int num_errors, checks;
    // Rows: index, written byte, byte read back
    logic [23:0] rows [10] = '{24'h3EFF07, 24'h3FA5A5, 24'h405A5A, 24'h41C3C3, 24'h423C3C,
        24'h438181, 24'h447E7E, 24'h45FFFF, 24'h460101, 24'h47FF07};

    knock_and_stillness_detector #(.TICK_CYCLES(4)) u_dut (.aclk, .aresetn, .ce, .sample,
        .events, .flags, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // Clock, 100 ns period
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic report_and_stop;
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Register write, one byte
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        s_axi_awaddr <= {3'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    // Register read
    task automatic rd(input logic [6:0] i);
        s_axi_araddr <= {3'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // One sample strobe
    task automatic put(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        sample <= {1'b1, x, y, z};
        @(posedge aclk);
        sample.valid <= 1'b0;
        @(posedge aclk);
    endtask

    // Knock of given length on one axis
    task automatic knock(input int ax, input logic [11:0] a, input int len);
        put(ax == 0 ? a : 12'h000, ax == 1 ? a : 12'h000, ax == 2 ? a : 12'h000);
        repeat (len) @(posedge aclk);
        put(12'h000, 12'h000, 12'h000);
        repeat (8) @(posedge aclk);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        sample = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        num_errors = 0;
        checks = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 10; k++) begin
            rd(rows[k][22:16]);
            `CHK(rd_d, 32'h0)
        end
        for (int k = 0; k < 10; k++) begin
            wr(rows[k][22:16], rows[k][15:8]);
            `CHK(rsp, RESP_OKAY)
            rd(rows[k][22:16]);
            `CHK(rd_d, {24'h0, rows[k][7:0]})
        end
        // Unmapped place
        wr(7'h30, 8'h55);
        `CHK(rsp, RESP_SLVERR)
        rd(7'h30);
        `CHK({rd_d, rsp}, {32'h0, RESP_SLVERR})
        wr(IDX_KNOCK_LEVEL, 8'h04);
        wr(IDX_KNOCK_MAX_LENGTH, 8'h01);
        wr(IDX_KNOCK_GAP_DELAY, 8'h00);
        wr(IDX_SECOND_KNOCK_WINDOW, 8'h02);
        for (int a = 0; a < 3; a++) begin
            wr(IDX_KNOCK_SETUP, 8'(a));
            wr(IDX_EVENT_STATUS, 8'h0F);
            knock((a + 1) % 3, 12'h064, 8);
            `CHK(flags[FLAG_TAP], 1'b0)
            knock(a, 12'hF9C, 8);
            `CHK(flags[FLAG_TAP], 1'b1)
            knock(a, 12'h064, 8);
            `CHK(flags[FLAG_DOUBLE], 1'b0)
        end
        // Threshold edge and too long a knock
        wr(IDX_EVENT_STATUS, 8'h0F);
        knock(2, 12'h04F, 8);
        `CHK(flags[FLAG_TAP], 1'b0)
        knock(2, 12'h064, 60);
        `CHK(flags[FLAG_TAP], 1'b0)
        knock(2, 12'h050, 8);
        `CHK(flags[FLAG_TAP], 1'b1)
        // Second knock in gap, then in window
        wr(IDX_KNOCK_GAP_DELAY, 8'h01);
        wr(IDX_EVENT_STATUS, 8'h0F);
        knock(2, 12'h064, 8);
        knock(2, 12'h064, 8);
        `CHK(flags[FLAG_DOUBLE], 1'b0)
        repeat (30) @(posedge aclk);
        knock(2, 12'h064, 8);
        `CHK(flags[FLAG_DOUBLE], 1'b1)
        repeat (200) @(posedge aclk);
        wr(IDX_EVENT_STATUS, 8'h0F);
        knock(2, 12'h064, 8);
        repeat (200) @(posedge aclk);
        knock(2, 12'h064, 8);
        `CHK(flags[FLAG_DOUBLE], 1'b0)
        repeat (200) @(posedge aclk);
        wr(IDX_KNOCK_SETUP, 8'h06);
        wr(IDX_EVENT_STATUS, 8'h0F);
        for (int k = 0; k < 3; k++) begin
            knock(2, 12'h064, 8);
            repeat (40) @(posedge aclk);
        end
        `CHK(flags[2:0], 3'h7)
        rd(IDX_EVENT_STATUS);
        `CHK(rd_d[2:0], 3'h7)
        wr(IDX_EVENT_STATUS, 8'h0F);
        `CHK(flags[2:0], 3'h0)
        wr(IDX_KNOCK_LEVEL, 8'h00);
        knock(2, 12'h064, 8);
        `CHK(flags[FLAG_TAP], 1'b0)
        // Write with byte lane 0 off stores nothing
        s_axi_wstrb <= 4'hE;
        wr(IDX_KNOCK_LEVEL, 8'h33);
        s_axi_wstrb <= 4'hF;
        rd(IDX_KNOCK_LEVEL);
        `CHK(rd_d, 32'h0)
        // Stillness: level 256, time two units
        wr(IDX_STILL_LEVEL_HIGH, 8'h01);
        wr(IDX_STILL_LEVEL_LOW, 8'h00);
        wr(IDX_STILL_TIME_HIGH, 8'h00);
        wr(IDX_STILL_TIME_MID, 8'h00);
        wr(IDX_STILL_TIME_LOW, 8'h02);
        put(12'h000, 12'h000, 12'h010);
        wr(IDX_EVENT_STATUS, 8'h0F);
        repeat (24) @(posedge aclk);
        `CHK(flags[FLAG_STILL], 1'b0)
        put(12'h000, 12'hFF1, 12'h00F);
        repeat (20) @(posedge aclk);
        `CHK(flags[FLAG_STILL], 1'b0)
        repeat (30) @(posedge aclk);
        `CHK(flags[FLAG_STILL], 1'b1)
        report_and_stop();
    end
endmodule // tb_top

/* tick_divider.sv */
`timescale 1ns/1ps
module tick_divider
    import knock_pkg::*;
#(
    parameter int DIV = BASE_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    output logic tick
);

    initial begin
        if (DIV < 2 || DIV > 65535) begin
            $error("tick_divider: DIV out of range");
        end
    end

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    // Free-running count, one pulse per period
    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff == 16'(DIV - 1)) begin
            nxt_cnt = 16'h0000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff & ce;

endmodule // tick_divider
